// *** pwr_seq_pkg.sv ***
// Package of constants and state codes for the power-state sequencer.
// Assumes a single 40 MHz clock shared by every module that imports it.
package pwr_seq_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int KEY_MIN_US = 1000;
   localparam int RST_MIN_US = 1000;
   localparam int SETTLE_US = 100;
   localparam int KEY_MIN_CYC = (KEY_MIN_US * 1000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int RST_MIN_CYC = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int CNT_W = 20;

   // ************************************************************
   // Sequencer states
   // ************************************************************
   typedef enum logic [5:0] {
      ST_NOPWR = 6'h01,
      ST_SETTLE = 6'h02,
      ST_OFF = 6'h04,
      ST_ON = 6'h08,
      ST_SAVE = 6'h10,
      ST_DETACH = 6'h20
   } seq_state_e;

   // ************************************************************
   // Reasons for leaving the on state
   // ************************************************************
   localparam logic [1:0] EXIT_POWEROFF = 2'h0;
   localparam logic [1:0] EXIT_REBOOT = 2'h1;

endpackage : pwr_seq_pkg

// *** low_pulse_filter.sv ***
// Measures low pulses on a pulled-up active-low line.
// Assumes the line is already synchronous to the clock.
`timescale 1ns/1ps
module low_pulse_filter
   import pwr_seq_pkg::*;
#(
   parameter int MIN_CYC = 40000
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic line_n_in,
   output logic long_low_out,
   output logic valid_pulse_out,
   output logic rise_out
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic prev_n;
      logic long_low;
      logic valid_pulse;
      logic rise;
   } flt_s;

   flt_s st_q;
   flt_s st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.prev_n = line_n_in;
      st_d.valid_pulse = 1'b0;
      st_d.rise = 1'b0;
      if (!line_n_in)
      begin
         if (st_q.cnt != CNT_W'(MIN_CYC))
         begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
         end
         // Short glitches never reach the width.
         st_d.long_low = (st_q.cnt == CNT_W'(MIN_CYC));
      end
      else
      begin
         st_d.cnt = '0;
         st_d.long_low = 1'b0;
         if (!st_q.prev_n)
         begin
            st_d.rise = 1'b1;
            st_d.valid_pulse = (st_q.cnt == CNT_W'(MIN_CYC));
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_q <= '{cnt: '0, prev_n: 1'b1, long_low: 1'b0,
                   valid_pulse: 1'b0, rise: 1'b0};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign long_low_out = st_q.long_low;
   assign valid_pulse_out = st_q.valid_pulse;
   assign rise_out = st_q.rise;

endmodule : low_pulse_filter

// *** power_state_sequencer.sv ***
// Power-state sequencer: decides switch-on, graceful power-off,
// abrupt shutdown and reboot of the module.
// Assumes all inputs are synchronous to MCLK_IN; the firmware answers
// the save and detach requests with one-cycle done pulses.
`timescale 1ns/1ps
// Summary of operation
// - A power-key or reset line held low while supply rises keeps the device off until released after settling.
// - From off with good supply, a valid low pulse on the power key switches the device on.
// - From off, a rising edge on the reset line switches the device on.
// - From off, a reached alarm switches the device on.
// - A power-off command or valid key pulse while on saves settings, detaches, then powers off.
// - Loss of supply shuts down abruptly with no save and no detach.
// - A low reset line while on shuts down abruptly with no save and no detach.
// - An enabled temperature supervisor reporting a danger region shuts the device down.
// - A function-level reset command saves, detaches and reboots.
// - A valid reset low turns off the interface rail and tri-states pins but keeps RTC and backup supply.
// - A hardware reset performs neither save nor detach.
// - The interface supply rail is enabled only while switched on.
module power_state_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int KEY_CYC = KEY_MIN_CYC,
   parameter int RST_CYC = RST_MIN_CYC,
   parameter int SETTLE_CNT = SETTLE_CYC
)
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic SUPPLY_GOOD_IN,
   input wire logic POWER_KEY_LINE_N_IN,
   input wire logic RESET_LINE_N_IN,
   input wire logic ALARM_DUE_IN,
   input wire logic POWEROFF_COMMAND_IN,
   input wire logic FUNCTION_LEVEL_COMMAND_IN,
   input wire logic TEMP_SUPERVISOR_EN_IN,
   input wire logic TEMP_DANGER_IN,
   input wire logic SAVE_DONE_IN,
   input wire logic DETACH_DONE_IN,
   output logic IF_RAIL_EN_OUT,
   output logic PINS_TRISTATE_OUT,
   output logic BACKUP_RTC_EN_OUT,
   output logic SAVE_REQ_OUT,
   output logic DETACH_REQ_OUT,
   output logic ABRUPT_OUT,
   output logic REBOOT_OUT
);

   // ************************************************************
   // Pulse filters on the two pulled-up lines
   // ************************************************************
   logic key_pulse;
   logic rst_long;
   logic rst_rise;

   low_pulse_filter #(.MIN_CYC(KEY_CYC)) u_key_flt (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .line_n_in(POWER_KEY_LINE_N_IN),
      .long_low_out(),
      .valid_pulse_out(key_pulse),
      .rise_out()
   );

   low_pulse_filter #(.MIN_CYC(RST_CYC)) u_rst_flt (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .line_n_in(RESET_LINE_N_IN),
      .long_low_out(rst_long),
      .valid_pulse_out(),
      .rise_out(rst_rise)
   );

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      seq_state_e state;
      logic [CNT_W-1:0] cnt;
      logic held;
      logic [1:0] reason;
      logic rail;
      logic tri_st;
      logic save_req;
      logic detach_req;
      logic abrupt;
      logic reboot;
   } seq_s;

   seq_s st_q;
   seq_s st_d;

   // A line counts as held once it has been low for any time.
   function automatic logic lines_low(input logic k_n, input logic r_n);
      lines_low = !k_n || !r_n;
   endfunction : lines_low

   always_comb
   begin
      st_d = st_q;
      st_d.abrupt = 1'b0;
      st_d.reboot = 1'b0;
      if (!SUPPLY_GOOD_IN)
      begin
         // Supply loss wins over everything, no save or detach.
         st_d.abrupt = (st_q.state != ST_NOPWR) && (st_q.state != ST_OFF);
         st_d.state = ST_NOPWR;
         st_d.held = 1'b0;
         st_d.save_req = 1'b0;
         st_d.detach_req = 1'b0;
      end
      else
      begin
         case (st_q.state)
            ST_NOPWR:
            begin
               st_d.state = ST_SETTLE;
               st_d.cnt = '0;
               st_d.held = lines_low(POWER_KEY_LINE_N_IN, RESET_LINE_N_IN);
            end
            ST_SETTLE:
            begin
               if (lines_low(POWER_KEY_LINE_N_IN, RESET_LINE_N_IN))
               begin
                  st_d.held = 1'b1;
               end
               if (st_q.cnt == CNT_W'(SETTLE_CNT))
               begin
                  // Held lines defer switch-on until released.
                  // A released hold costs one more cycle, so that the late
                  // filter pulse of that release is not taken for a
                  // power-off request once the device is on.
                  if (!lines_low(POWER_KEY_LINE_N_IN, RESET_LINE_N_IN))
                  begin
                     if (st_q.held)
                     begin
                        st_d.held = 1'b0;
                     end
                     else
                     begin
                        st_d.state = ST_ON;
                     end
                  end
               end
               else
               begin
                  st_d.cnt = st_q.cnt + CNT_W'(1);
               end
            end
            ST_OFF:
            begin
               // Reset-line release, key pulse or alarm wake the device.
               if (rst_rise)
               begin
                  st_d.state = ST_ON;
               end
               else if (key_pulse)
               begin
                  st_d.state = ST_ON;
               end
               else if (ALARM_DUE_IN)
               begin
                  st_d.state = ST_ON;
               end
            end
            ST_ON:
            begin
               if (!RESET_LINE_N_IN)
               begin
                  // Abrupt shutdown: no save, no detach.
                  st_d.state = ST_OFF;
                  st_d.abrupt = 1'b1;
               end
               else if (TEMP_SUPERVISOR_EN_IN && TEMP_DANGER_IN)
               begin
                  st_d.state = ST_OFF;
                  st_d.abrupt = 1'b1;
               end
               else if (POWEROFF_COMMAND_IN || key_pulse)
               begin
                  st_d.state = ST_SAVE;
                  st_d.save_req = 1'b1;
                  st_d.reason = EXIT_POWEROFF;
               end
               else if (FUNCTION_LEVEL_COMMAND_IN)
               begin
                  st_d.state = ST_SAVE;
                  st_d.save_req = 1'b1;
                  st_d.reason = EXIT_REBOOT;
               end
            end
            ST_SAVE:
            begin
               if (!RESET_LINE_N_IN)
               begin
                  st_d.state = ST_OFF;
                  st_d.save_req = 1'b0;
                  st_d.abrupt = 1'b1;
               end
               else if (SAVE_DONE_IN)
               begin
                  st_d.save_req = 1'b0;
                  st_d.detach_req = 1'b1;
                  st_d.state = ST_DETACH;
               end
            end
            ST_DETACH:
            begin
               if (!RESET_LINE_N_IN)
               begin
                  st_d.state = ST_OFF;
                  st_d.detach_req = 1'b0;
                  st_d.abrupt = 1'b1;
               end
               else if (DETACH_DONE_IN)
               begin
                  st_d.detach_req = 1'b0;
                  if (st_q.reason == EXIT_REBOOT)
                  begin
                     st_d.reboot = 1'b1;
                     st_d.state = ST_ON;
                  end
                  else
                  begin
                     st_d.state = ST_OFF;
                  end
               end
            end
            default:
            begin
               st_d.state = ST_NOPWR;
            end
         endcase
      end
      // Rail on only while switched on; pins float otherwise.
      st_d.rail = (st_d.state == ST_ON) || (st_d.state == ST_SAVE) ||
                  (st_d.state == ST_DETACH);
      // Long reset low forces rail off and pins tri-state.
      if (rst_long)
      begin
         st_d.rail = 1'b0;
      end
      st_d.tri_st = !st_d.rail;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (RST_IN)
      begin
         st_q <= '{state: ST_NOPWR, cnt: '0, held: 1'b0,
                   reason: EXIT_POWEROFF, rail: 1'b0, tri_st: 1'b1,
                   save_req: 1'b0, detach_req: 1'b0, abrupt: 1'b0,
                   reboot: 1'b0};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // The RTC and backup supply never drop, even under a reset.
   logic rtc_en_q;
   always_ff @(posedge MCLK_IN)
   begin
      rtc_en_q <= 1'b1;
   end

   assign IF_RAIL_EN_OUT = st_q.rail;
   assign PINS_TRISTATE_OUT = st_q.tri_st;
   assign BACKUP_RTC_EN_OUT = rtc_en_q;
   assign SAVE_REQ_OUT = st_q.save_req;
   assign DETACH_REQ_OUT = st_q.detach_req;
   assign ABRUPT_OUT = st_q.abrupt;
   assign REBOOT_OUT = st_q.reboot;

endmodule : power_state_sequencer

// *** pwr_host_model.sv ***
// Host model: open-drain drivers of the power key and reset lines.
// Assumes internal pull-ups, so a released line reads high.
`timescale 1ns/1ps
module pwr_host_model
(
   input wire logic key_pull_in,
   input wire logic rst_pull_in,
   output logic key_line_n_out,
   output logic rst_line_n_out
);
   // ****
   // Lines
   // ****
   assign key_line_n_out = !key_pull_in;
   assign rst_line_n_out = !rst_pull_in;
endmodule : pwr_host_model

// *** power_state_sequencer_props.sv ***
// Property checker of the power-state sequencer, bound to its ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module power_state_sequencer_props
#(
   parameter int KEY_CYC = 8,
   parameter int RST_CYC = 8,
   parameter int SETTLE_CNT = 4
)
(
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic SUPPLY_GOOD_IN,
   input wire logic RESET_LINE_N_IN,
   input wire logic POWEROFF_COMMAND_IN,
   input wire logic TEMP_DANGER_IN,
   input wire logic SAVE_DONE_IN,
   input wire logic IF_RAIL_EN_OUT,
   input wire logic PINS_TRISTATE_OUT,
   input wire logic BACKUP_RTC_EN_OUT,
   input wire logic SAVE_REQ_OUT,
   input wire logic DETACH_REQ_OUT,
   input wire logic ABRUPT_OUT,
   input wire logic REBOOT_OUT
);
   int low_q;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   // ****
   // Properties
   // ****
   // The count saturates so that a long hold never wraps back to zero.
   always_ff @(posedge MCLK_IN)
      low_q <= (RST_IN || RESET_LINE_N_IN) ? 0 : low_q + int'(low_q < RST_CYC);
   a_pins_follow: assert property (PINS_TRISTATE_OUT == !IF_RAIL_EN_OUT)
      else $error("pins vs rail");
   a_backup_kept: assert property (BACKUP_RTC_EN_OUT)
      else $error("backup off");
   a_reset_abrupt: assert property (IF_RAIL_EN_OUT && !RESET_LINE_N_IN
      |-> ##[1:2] !IF_RAIL_EN_OUT) else $error("reset kept rail");
   a_hw_nosave: assert property (!RESET_LINE_N_IN |=> !$rose(SAVE_REQ_OUT))
      else $error("save on reset");
   a_supply_loss: assert property (!SUPPLY_GOOD_IN |=> !IF_RAIL_EN_OUT)
      else $error("rail without supply");
   a_save_first: assert property ($rose(DETACH_REQ_OUT) |-> $past(SAVE_REQ_OUT))
      else $error("detach before save");
   a_save_held: assert property (SAVE_REQ_OUT && !SAVE_DONE_IN && RESET_LINE_N_IN
      && SUPPLY_GOOD_IN && !TEMP_DANGER_IN |=> SAVE_REQ_OUT) else $error("save dropped");
   a_reboot_live: assert property (REBOOT_OUT |-> IF_RAIL_EN_OUT && !DETACH_REQ_OUT)
      else $error("reboot state");
   a_cmd_saves: assert property (IF_RAIL_EN_OUT && POWEROFF_COMMAND_IN
      && !SAVE_REQ_OUT && !DETACH_REQ_OUT && !$past(DETACH_REQ_OUT) && !ABRUPT_OUT
      && RESET_LINE_N_IN && SUPPLY_GOOD_IN && !TEMP_DANGER_IN |=> SAVE_REQ_OUT)
      else $error("command not saved");
   a_long_reset: assert property (low_q >= RST_CYC |-> !IF_RAIL_EN_OUT)
      else $error("rail on in reset");
   c_rail_up: cover property ($rose(IF_RAIL_EN_OUT));
   c_abrupt: cover property (ABRUPT_OUT);
   c_reboot: cover property (REBOOT_OUT);
endmodule : power_state_sequencer_props

bind power_state_sequencer power_state_sequencer_props #(.KEY_CYC(KEY_CYC),
   .RST_CYC(RST_CYC), .SETTLE_CNT(SETTLE_CNT)) props_u (.MCLK_IN, .RST_IN,
   .SUPPLY_GOOD_IN, .RESET_LINE_N_IN, .POWEROFF_COMMAND_IN, .TEMP_DANGER_IN,
   .SAVE_DONE_IN, .IF_RAIL_EN_OUT, .PINS_TRISTATE_OUT, .BACKUP_RTC_EN_OUT,
   .SAVE_REQ_OUT, .DETACH_REQ_OUT, .ABRUPT_OUT, .REBOOT_OUT);

// *** power_state_sequencer_test.sv ***
// Self-checking bench of the power-state sequencer.
// Assumes short counts and firmware that answers at once or late.
`timescale 1ns/1ps
module power_state_sequencer_test;
   import pwr_seq_pkg::*;
   localparam int KC = 8;
   localparam int RC = 8;
   localparam logic [1:0] R = 2'h0, F = 2'h1, A = 2'h2, B = 2'h3;
   logic clk = 0, rst = 1, sup = 1, alm = 0, pc = 0, fc = 0, te = 0, td = 0;
   logic sd = 0, dd = 0, kp = 1, rp = 0, rail_p = 0, sr_p = 0;
   logic kn, rn, rail, tri_s, bk, sr, dr, ab, rb;
   int mismatches = 0, n_checks = 0, cyc = 0, ns = 0, s0, sw = 0, dw = 0;
   logic [1:0] q[$];
   initial forever #12.5 clk = !clk;
   pwr_host_model host_u (.key_pull_in(kp), .rst_pull_in(rp),
      .key_line_n_out(kn), .rst_line_n_out(rn));
   power_state_sequencer #(.KEY_CYC(KC), .RST_CYC(RC), .SETTLE_CNT(4)) dut_u (
      .MCLK_IN(clk), .RST_IN(rst), .SUPPLY_GOOD_IN(sup),
      .POWER_KEY_LINE_N_IN(kn), .RESET_LINE_N_IN(rn), .ALARM_DUE_IN(alm),
      .POWEROFF_COMMAND_IN(pc), .FUNCTION_LEVEL_COMMAND_IN(fc),
      .TEMP_SUPERVISOR_EN_IN(te), .TEMP_DANGER_IN(td), .SAVE_DONE_IN(sd),
      .DETACH_DONE_IN(dd), .IF_RAIL_EN_OUT(rail), .PINS_TRISTATE_OUT(tri_s),
      .BACKUP_RTC_EN_OUT(bk), .SAVE_REQ_OUT(sr), .DETACH_REQ_OUT(dr),
      .ABRUPT_OUT(ab), .REBOOT_OUT(rb));
   // ****
   // Tasks
   // ****
   task automatic complete_run;
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   // A later event than expected still lands before the queue check.
   task automatic wait_q;
      for (int i = 0; i < 300 && q.size() > 0; i++) @(negedge clk);
      cmp(8'(q.size()), 8'h0);
      idle(12);
   endtask : wait_q
   task automatic pulse(input logic k, input int n);
      if (k) rp = 1; else kp = 1;
      idle(n);
      kp = 0;
      rp = 0;
   endtask : pulse
   // ****
   // Watchers and firmware
   // ****
   always @(negedge clk)
   begin
      if (!rst && ab === 1'b1) cmp({6'h0, A}, q.size() ? q.pop_front() : 8'hff);
      if (!rst && rb === 1'b1) cmp({6'h0, B}, q.size() ? q.pop_front() : 8'hff);
      if (!rst && rail !== rail_p)
         cmp({6'h0, rail ? R : F}, q.size() ? q.pop_front() : 8'hff);
      if (!rst && rail !== rail_p)
         cmp({7'h0, tri_s}, {7'h0, !rail});
      rail_p = rail;
      if (sr === 1'b1 && sr_p !== 1'b1) ns++;
      sr_p = sr;
      sd <= 1'b0;
      dd <= 1'b0;
      if (sr === 1'b1 && sw == 0) begin sd <= 1; sw = $urandom % 4; end
      else if (sr === 1'b1) sw--;
      if (dr === 1'b1 && dw == 0) begin dd <= 1; dw = $urandom % 4; end
      else if (dr === 1'b1) dw--;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         complete_run;
      end
   end
   initial
   begin
      s0 = $urandom(58);
      idle(16);
      rst = 0;
      wait_q;
      q.push_back(R); kp = 0; wait_q;
      pulse(0, 1 + $urandom % (KC - 2)); wait_q;
      s0 = ns;
      q.push_back(F); pulse(0, KC); wait_q; cmp(8'(ns - s0), 8'h1);
      q.push_back(R); pulse(0, KC + $urandom % 4); wait_q;
      q.push_back(F); pc = 1; idle(1); pc = 0; wait_q;
      q.push_back(R); pulse(1, 2); wait_q;
      s0 = ns;
      q.push_back(B); fc = 1; idle(1); fc = 0; wait_q; cmp(8'(ns - s0), 8'h1);
      s0 = ns;
      q = {A, F, R}; pulse(1, RC + 2); wait_q; cmp(8'(ns - s0), 8'h0);
      cmp({7'h0, bk}, 8'h1);
      td = 1; wait_q; q = {A, F}; te = 1; wait_q; te = 0; td = 0;
      q.push_back(R); alm = 1; idle(1); alm = 0; wait_q;
      q = {A, F}; sup = 0; wait_q; q.push_back(R); sup = 1; wait_q;
      q = {A, F}; sup = 0; wait_q; rp = 1; sup = 1; wait_q;
      q.push_back(R); rp = 0; wait_q;
      complete_run;
   end
endmodule : power_state_sequencer_test
